// File: prot_pkg.sv
/*
  Shared constants for the LED fault protection sequencer: fault counts,
  hold-value step limits, timing figures and the power state encoding.
  Assumes a 200 MHz system clock and a common protection tick.
*/
`default_nettype none
package prot_pkg;

  // system clock rate and internal reset strobe length
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned RESET_STROBE_NS = 1000;
  localparam int unsigned RESET_STROBE_CYCLES = (RESET_STROBE_NS * CLK_MHZ) / 1000;
  localparam int unsigned RESET_STROBE_W = 8;

  // fault timer lengths in protection ticks
  localparam int unsigned OVP_LATCH_COUNT = 262152;
  localparam int unsigned SCP_LATCH_COUNT = 65536;
  localparam int unsigned LED_LATCH_COUNT = 65536;
  localparam int unsigned GND_SHORT_COUNT = 128;
  localparam int unsigned MASK_COUNT = 4;

  // channel count and hold-value quantisation
  localparam int unsigned NUM_CHANNELS = 6;
  localparam int unsigned OVP_HOLD_W = 5;
  localparam int unsigned FB_HOLD_W = 6;
  localparam logic [4:0] OVP_HOLD_STEPS = 5'h1E;
  localparam logic [5:0] FB_HOLD_STEPS = 6'h28;

  // values after reset
  localparam logic [4:0] OVP_HOLD_RESET = 5'h00;
  localparam logic [5:0] FB_HOLD_RESET = 6'h00;

  // power sequencing states
  typedef enum logic [1:0] {
    PS_OFF = 2'b00,
    PS_RUN = 2'b01,
    PS_DOWN = 2'b10
  } pwr_state_e;

endpackage : prot_pkg
`default_nettype wire

// File: channel_fault_timer.sv
/*
  Per-channel LED fault timer: dimming-high mask, short/open detect timer,
  latches, pull-up request and ground-short escalation.
  Assumes detector inputs and tick are synchronous to clk.
*/
`timescale 1ns/10ps
`default_nettype none
module channel_fault_timer
  import prot_pkg::*;
#(
  parameter int unsigned DET_COUNT = LED_LATCH_COUNT
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic tick,
  input wire logic armed,
  input wire logic dimming,
  input wire logic short_det,
  input wire logic open_det,
  output logic short_latched,
  output logic open_latched,
  output logic gnd_fault
);

  localparam int DW = $clog2(DET_COUNT + 1);
  localparam int GW = $clog2(GND_SHORT_COUNT + 1);
  localparam int MW = $clog2(MASK_COUNT + 1);

  logic [MW-1:0] mask_cnt_reg;
  logic [MW-1:0] mask_cnt_next;
  logic [DW-1:0] det_cnt_reg;
  logic [DW-1:0] det_cnt_next;
  logic [GW-1:0] gnd_cnt_reg;
  logic [GW-1:0] gnd_cnt_next;
  logic short_lat_reg;
  logic open_lat_reg;
  logic gnd_lat_reg;

  // mask and detect qualification
  wire mask_done = mask_cnt_reg == MW'(MASK_COUNT);
  wire any_lat = short_lat_reg | open_lat_reg;
  wire det_now = armed & mask_done & !any_lat & (short_det | open_det);
  wire det_done = det_now & tick & (det_cnt_reg == DW'(DET_COUNT - 1));
  wire gnd_run = open_lat_reg & open_det & !gnd_lat_reg;
  wire gnd_done = gnd_run & tick & (gnd_cnt_reg == GW'(GND_SHORT_COUNT - 1));

  // mask restarts at every dimming-high interval
  assign mask_cnt_next = !dimming ? '0 : (tick & !mask_done) ? mask_cnt_reg + 1'b1 : mask_cnt_reg;
  // detect timer holds while dimming is low, clears when the fault goes away
  assign det_cnt_next = det_now ? (tick ? det_cnt_reg + 1'b1 : det_cnt_reg) : (dimming ? '0 : det_cnt_reg);
  // pin still low with pull-up applied: count toward a system latch
  assign gnd_cnt_next = gnd_run ? (tick ? gnd_cnt_reg + 1'b1 : gnd_cnt_reg) : '0;

  // counters
  always_ff @(posedge clk) begin
    if (rst || clear) begin
      mask_cnt_reg <= '0;
      det_cnt_reg <= '0;
      gnd_cnt_reg <= '0;
    end else begin
      mask_cnt_reg <= mask_cnt_next;
      det_cnt_reg <= det_cnt_next;
      gnd_cnt_reg <= gnd_cnt_next;
    end
  end

  // latches: a new set wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      short_lat_reg <= 1'b0;
      open_lat_reg <= 1'b0;
      gnd_lat_reg <= 1'b0;
    end else begin
      short_lat_reg <= (short_lat_reg & !clear) | (det_done & short_det);
      open_lat_reg <= (open_lat_reg & !clear) | (det_done & open_det & !short_det);
      gnd_lat_reg <= (gnd_lat_reg & !clear) | gnd_done;
    end
  end

  assign short_latched = short_lat_reg;
  assign open_latched = open_lat_reg;
  assign gnd_fault = gnd_lat_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_MASK_RESTART: assert property (!dimming |=> mask_cnt_reg == '0 && !det_now)
    else $error("mask not restarted while dimming low");
  AST_CH_STICKY: assert property (any_lat && !clear |=> short_lat_reg || open_lat_reg)
    else $error("channel latch dropped without clear");
  AST_NO_DETECT_IN_MASK: assert property (!mask_done && !any_lat |=> !short_lat_reg && !open_lat_reg)
    else $error("channel latched inside mask interval");

endmodule : channel_fault_timer
`default_nettype wire

// File: led_fault_protection_sequencer.sv
/*
  Protection and sequencing logic of a six-channel LED backlight driver:
  supply/enable sequencing, system fault timers, per-channel fault timers,
  converter gating, dimming hold values and the open-drain fault flag.
  Assumes all comparator results and the protection tick are synchronous
  to CLK; the analog converter and current regulation sit outside.
*/
`timescale 1ns/10ps
`default_nettype none
// Function
// - fault flag pulled low normally, released open after a timed fault latch
// - overvoltage lower trip runs timer, drop clears it, completion latches system
// - overvoltage upper trip stops converter at once, timer keeps running
// - output short stops converter, timer completion latches converter and LEDs off
// - dimming falling edge captures output-voltage level, 30 steps, held while low
// - channel short runs its timer, completion turns only that channel off
// - channel open runs its timer, completion stops only that channel
// - latched-open channel pulled up; still low 128 counts latches system
// - four-count mask at each dimming-high interval before LED timers run
// - step-up enabled at upper lockout threshold, disabled at lower one
// - enable toggles device, passing through off clears latched faults
// - fault timers keep counting during shutdown until shutdown completes; channel timers are held clear during the reset strobe
// - supply lockout upper threshold starts device, lower threshold stops all
// - current limit forcibly ends gate-drive switching
// - low frequency-set pin halts converter, resumes automatically
// - dimming falling edge captures feedback level, 40 steps, held while low
// - while dimming low in the run state, output-voltage sense serves as feedback source
// - soft-start completion ends soft start and arms LED protection
// - low current-set pin turns LEDs off and opens flag, recovery restores
// - enable going off issues brief internal reset, LED drivers keep going
module led_fault_protection_sequencer
  import prot_pkg::*;
#(
  parameter int unsigned OVP_COUNT = OVP_LATCH_COUNT,
  parameter int unsigned SCP_COUNT = SCP_LATCH_COUNT,
  parameter int unsigned LED_COUNT = LED_LATCH_COUNT,
  parameter int unsigned CH = NUM_CHANNELS
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic TICK,
  input wire logic STANDBY_ENABLE,
  input wire logic LOCKOUT_ABOVE_HI,
  input wire logic LOCKOUT_BELOW_LO,
  input wire logic STEPUP_ABOVE_HI,
  input wire logic STEPUP_BELOW_LO,
  input wire logic OVERVOLTAGE_ABOVE_LO,
  input wire logic OVERVOLTAGE_ABOVE_HI,
  input wire logic OUTPUT_SHORT_PROTECT,
  input wire logic INDUCTOR_CURRENT_LIMIT,
  input wire logic FREQUENCY_SET_LOW,
  input wire logic CURRENT_SET_LOW,
  input wire logic SOFTSTART_DONE,
  input wire logic SHUTDOWN_DONE,
  input wire logic [CH-1:0] DIMMING,
  input wire logic [CH-1:0] CHANNEL_SHORT,
  input wire logic [CH-1:0] CHANNEL_OPEN_FLAG,
  input wire logic [OVP_HOLD_W-1:0] OVERVOLTAGE_LEVEL,
  input wire logic [FB_HOLD_W-1:0] FEEDBACK_LEVEL,
  output logic FAULT_FLAG_O,
  output logic FAULT_FLAG_OE,
  output logic CONVERTER_ENABLE,
  output logic [CH-1:0] CHANNEL_OUTPUTS,
  output logic [CH-1:0] CHANNEL_PULLUP,
  output logic [OVP_HOLD_W-1:0] OVERVOLTAGE_HOLD,
  output logic [FB_HOLD_W-1:0] FEEDBACK_HOLD,
  output logic FEEDBACK_FROM_OVERVOLTAGE,
  output logic INTERNAL_RESET,
  output logic DEVICE_ACTIVE,
  output logic STEPUP_ENABLE,
  output logic LED_PROTECT_ARMED,
  output logic SYSTEM_LATCHED
);

  localparam int OW = $clog2(OVP_COUNT + 1);
  localparam int SW = $clog2(SCP_COUNT + 1);

  pwr_state_e state_reg;
  pwr_state_e state_next;
  logic supply_ok_reg;
  logic stepup_ok_reg;
  logic [RESET_STROBE_W-1:0] rst_cnt_reg;
  logic [RESET_STROBE_W-1:0] rst_cnt_next;
  logic [OW-1:0] ovp_cnt_reg;
  logic [OW-1:0] ovp_cnt_next;
  logic [SW-1:0] scp_cnt_reg;
  logic [SW-1:0] scp_cnt_next;
  logic sys_latch_reg;
  logic armed_reg;
  logic dim_prev_reg;
  logic [OVP_HOLD_W-1:0] ovp_hold_reg;
  logic [FB_HOLD_W-1:0] fb_hold_reg;
  logic conv_en_reg;
  logic [CH-1:0] ch_en_reg;
  logic flag_oe_reg;
  logic ireset_reg;
  logic act_reg;
  logic fbov_reg;
  logic [CH-1:0] ch_short_lat;
  logic [CH-1:0] ch_open_lat;
  logic [CH-1:0] ch_gnd;

  // power state decoding
  wire in_run = state_reg == PS_RUN;
  wire in_down = state_reg == PS_DOWN;
  wire in_off = state_reg == PS_OFF;
  wire enable_fall = in_run & !STANDBY_ENABLE;
  wire strobe_live = rst_cnt_reg != '0;
  wire latch_clear = strobe_live | in_off;

  // dimming edge and hold-value quantisation
  wire dim_any = |DIMMING;
  wire dim_fall = dim_prev_reg & !dim_any;
  wire [OVP_HOLD_W-1:0] ovp_capped = (OVERVOLTAGE_LEVEL > OVP_HOLD_STEPS) ? OVP_HOLD_STEPS : OVERVOLTAGE_LEVEL;
  wire [FB_HOLD_W-1:0] fb_capped = (FEEDBACK_LEVEL > FB_HOLD_STEPS) ? FB_HOLD_STEPS : FEEDBACK_LEVEL;

  // system fault timers
  wire ovp_run = OVERVOLTAGE_ABOVE_LO & !sys_latch_reg & !in_off;
  wire ovp_done = ovp_run & TICK & (ovp_cnt_reg == OW'(OVP_COUNT - 1));
  wire scp_run = OUTPUT_SHORT_PROTECT & !sys_latch_reg & !in_off;
  wire scp_done = scp_run & TICK & (scp_cnt_reg == SW'(SCP_COUNT - 1));
  wire gnd_any = |ch_gnd;
  wire ch_any_lat = |(ch_short_lat | ch_open_lat);

  // converter gating and channel drive terms
  wire conv_stop = OVERVOLTAGE_ABOVE_HI | OUTPUT_SHORT_PROTECT | INDUCTOR_CURRENT_LIMIT | FREQUENCY_SET_LOW;
  wire conv_allow = in_run & stepup_ok_reg & !sys_latch_reg & !conv_stop;
  wire led_allow = (in_run | in_down) & !sys_latch_reg & !CURRENT_SET_LOW;
  wire [CH-1:0] ch_allow = {CH{led_allow}} & ~(ch_short_lat | ch_open_lat);
  wire flag_open = sys_latch_reg | ch_any_lat | CURRENT_SET_LOW;

  // power sequencing
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      PS_OFF: begin
        if (supply_ok_reg && STANDBY_ENABLE) begin
          state_next = PS_RUN;
        end
      end
      PS_RUN: begin
        if (!supply_ok_reg) begin
          state_next = PS_OFF;
        end else if (!STANDBY_ENABLE) begin
          state_next = PS_DOWN;
        end
      end
      PS_DOWN: begin
        if (!supply_ok_reg || SHUTDOWN_DONE) begin
          state_next = PS_OFF;
        end else if (STANDBY_ENABLE) begin
          state_next = PS_RUN;
        end
      end
      default: begin
        state_next = PS_OFF;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      state_reg <= PS_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  // supply lockout and step-up hysteresis
  always_ff @(posedge CLK) begin
    if (RST) begin
      supply_ok_reg <= 1'b0;
      stepup_ok_reg <= 1'b0;
    end else begin
      supply_ok_reg <= LOCKOUT_ABOVE_HI | (supply_ok_reg & !LOCKOUT_BELOW_LO);
      stepup_ok_reg <= STEPUP_ABOVE_HI | (stepup_ok_reg & !STEPUP_BELOW_LO);
    end
  end

  // internal reset strobe when enable goes away
  assign rst_cnt_next = enable_fall ? RESET_STROBE_W'(RESET_STROBE_CYCLES) : strobe_live ? rst_cnt_reg - 1'b1 : '0;

  always_ff @(posedge CLK) begin
    if (RST) begin
      rst_cnt_reg <= '0;
      ireset_reg <= 1'b0;
    end else begin
      rst_cnt_reg <= rst_cnt_next;
      ireset_reg <= rst_cnt_next != '0;
    end
  end

  // overvoltage and short timers; kept through shutdown, cleared when off, when their sense drops or once the system latches
  assign ovp_cnt_next = ovp_run ? (TICK ? ovp_cnt_reg + 1'b1 : ovp_cnt_reg) : '0;
  assign scp_cnt_next = scp_run ? (TICK ? scp_cnt_reg + 1'b1 : scp_cnt_reg) : '0;

  always_ff @(posedge CLK) begin
    if (RST || in_off) begin
      ovp_cnt_reg <= '0;
      scp_cnt_reg <= '0;
    end else begin
      ovp_cnt_reg <= ovp_cnt_next;
      scp_cnt_reg <= scp_cnt_next;
    end
  end

  // system latch: a new fault wins over the clear
  always_ff @(posedge CLK) begin
    if (RST) begin
      sys_latch_reg <= 1'b0;
    end else begin
      sys_latch_reg <= (sys_latch_reg & !latch_clear) | ovp_done | scp_done | gnd_any;
    end
  end

  // soft-start completion arms the LED protection
  always_ff @(posedge CLK) begin
    if (RST) begin
      armed_reg <= 1'b0;
    end else begin
      armed_reg <= !in_off & (armed_reg | (in_run & SOFTSTART_DONE));
    end
  end

  // dimming hold values captured at the falling edge
  always_ff @(posedge CLK) begin
    if (RST) begin
      dim_prev_reg <= 1'b0;
      ovp_hold_reg <= OVP_HOLD_RESET;
      fb_hold_reg <= FB_HOLD_RESET;
    end else begin
      dim_prev_reg <= dim_any;
      if (dim_fall) begin
        ovp_hold_reg <= ovp_capped;
        fb_hold_reg <= fb_capped;
      end
    end
  end

  // registered drive outputs
  always_ff @(posedge CLK) begin
    if (RST) begin
      conv_en_reg <= 1'b0;
      ch_en_reg <= '0;
      flag_oe_reg <= 1'b0;
    end else begin
      conv_en_reg <= conv_allow;
      ch_en_reg <= ch_allow;
      flag_oe_reg <= !flag_open;
    end
  end

  // registered run status and feedback source select
  always_ff @(posedge CLK) begin
    if (RST) begin
      act_reg <= 1'b0;
      fbov_reg <= 1'b0;
    end else begin
      act_reg <= state_next == PS_RUN;
      fbov_reg <= !dim_any & (state_next == PS_RUN);
    end
  end

  // per-channel fault timers sharing the tick
  for (genvar i = 0; i < CH; i++) begin : g_ch
    channel_fault_timer #(
      .DET_COUNT(LED_COUNT)
    ) u_timer (
      .clk(CLK),
      .rst(RST),
      .clear(latch_clear),
      .tick(TICK),
      .armed(armed_reg & led_allow),
      .dimming(DIMMING[i]),
      .short_det(CHANNEL_SHORT[i]),
      .open_det(CHANNEL_OPEN_FLAG[i]),
      .short_latched(ch_short_lat[i]),
      .open_latched(ch_open_lat[i]),
      .gnd_fault(ch_gnd[i])
    );
  end

  // output wiring, all from flip-flops except the constant-low FAULT_FLAG_O
  assign FAULT_FLAG_O = 1'b0;
  assign FAULT_FLAG_OE = flag_oe_reg;
  assign CONVERTER_ENABLE = conv_en_reg;
  assign CHANNEL_OUTPUTS = ch_en_reg;
  assign CHANNEL_PULLUP = ch_open_lat;
  assign OVERVOLTAGE_HOLD = ovp_hold_reg;
  assign FEEDBACK_HOLD = fb_hold_reg;
  assign FEEDBACK_FROM_OVERVOLTAGE = fbov_reg;
  assign INTERNAL_RESET = ireset_reg;
  assign DEVICE_ACTIVE = act_reg;
  assign STEPUP_ENABLE = stepup_ok_reg;
  assign LED_PROTECT_ARMED = armed_reg;
  assign SYSTEM_LATCHED = sys_latch_reg;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  sequence s_enable_drop;
    in_run && !STANDBY_ENABLE && supply_ok_reg;
  endsequence

  sequence s_strobe_held;
    INTERNAL_RESET [*8];
  endsequence

  AST_FLAG_OPEN_ON_LATCH: assert property (sys_latch_reg |=> !FAULT_FLAG_OE)
    else $error("fault flag not released after system latch");
  AST_FLAG_LOW_NORMAL: assert property (!flag_open |=> FAULT_FLAG_OE && !FAULT_FLAG_O)
    else $error("fault flag not pulled low in normal state");
  AST_OVP_CLEAR: assert property (!OVERVOLTAGE_ABOVE_LO |=> ovp_cnt_reg == '0)
    else $error("overvoltage timer kept count after sense dropped");
  AST_OVP_LATCH: assert property (ovp_done |=> SYSTEM_LATCHED)
    else $error("overvoltage timer completion did not latch");
  AST_OVP_STOP: assert property (OVERVOLTAGE_ABOVE_HI |=> !CONVERTER_ENABLE)
    else $error("converter still enabled above upper overvoltage trip");
  AST_OVP_KEEPS_COUNT: assert property (ovp_run && TICK && !ovp_done |=> ovp_cnt_reg == $past(ovp_cnt_reg) + 1'b1)
    else $error("overvoltage timer not advancing");
  AST_SCP_LATCH: assert property (scp_done |=> ##1 CHANNEL_OUTPUTS == '0 && !CONVERTER_ENABLE)
    else $error("short latch left converter or channels running");
  AST_HOLD_CAPTURE: assert property (dim_fall |=> OVERVOLTAGE_HOLD == $past(ovp_capped) && FEEDBACK_HOLD == $past(fb_capped))
    else $error("hold values not captured at dimming fall");
  AST_HOLD_STABLE: assert property (!dim_any && !dim_prev_reg |=> $stable(FEEDBACK_HOLD))
    else $error("feedback hold changed while dimming low");
  AST_FB_SOURCE: assert property (in_run && !dim_any ##1 in_run |-> FEEDBACK_FROM_OVERVOLTAGE)
    else $error("feedback source not switched while dimming low");
  AST_STEPUP_OFF: assert property (STEPUP_BELOW_LO && !STEPUP_ABOVE_HI |=> !STEPUP_ENABLE ##1 !CONVERTER_ENABLE)
    else $error("step-up not disabled at lower threshold");
  AST_CURRENT_LIMIT: assert property (INDUCTOR_CURRENT_LIMIT |=> !CONVERTER_ENABLE)
    else $error("gate drive not stopped at current limit");
  AST_FREQ_LOW: assert property (FREQUENCY_SET_LOW |=> !CONVERTER_ENABLE)
    else $error("converter running with frequency-set pin low");
  AST_CURRENT_SET_PIN_LOW: assert property (CURRENT_SET_LOW |=> CHANNEL_OUTPUTS == '0 && !FAULT_FLAG_OE)
    else $error("low current-set pin did not stop LEDs or open flag");
  AST_RESET_STROBE: assert property (s_enable_drop |=> s_strobe_held)
    else $error("internal reset strobe too short");
  AST_LOCKOUT_OFF: assert property (LOCKOUT_BELOW_LO && !LOCKOUT_ABOVE_HI |=> ##1 !DEVICE_ACTIVE)
    else $error("device still active after supply lockout");
  AST_SHUTDOWN_COUNT: assert property (in_down && scp_run && TICK && !scp_done |=> scp_cnt_reg != '0)
    else $error("fault timer stopped during shutdown");
  AST_ARM_SOFTSTART: assert property (in_run && SOFTSTART_DONE |=> LED_PROTECT_ARMED)
    else $error("LED protection not armed after soft start");
  AST_CH_FLAG: assert property (ch_any_lat |=> !FAULT_FLAG_OE)
    else $error("channel latch did not open fault flag");

endmodule : led_fault_protection_sequencer
`default_nettype wire

// File: analog_side.sv
/*
  Far-side model: sense comparators, channel pins and the short threshold setting.
  Assumes the bench sets the analog levels in millivolts just after a clock edge.
*/
`timescale 1ns/10ps
`default_nettype none
module analog_side (
  input wire logic [5:0] pull_req,
  input var int vout_mv,
  input var int lsp_mv,
  input var int led_mv [6],
  input wire logic [5:0] gnd_short,
  output logic ovp_lo,
  output logic ovp_hi,
  output logic [4:0] ovp_code,
  output logic [5:0] ch_short,
  output logic [5:0] ch_open
);
  int pin_mv [6];
  int short_mv;
  // short trip is ten times the setting, 9 V when the setting floats
  assign short_mv = (lsp_mv == 0) ? 9000 : 10 * lsp_mv;
  // output sense trip points and 0.1 V sense code
  assign ovp_lo = vout_mv > 2900;
  assign ovp_hi = vout_mv > 3000;
  assign ovp_code = 5'((vout_mv >= 3000) ? 30 : vout_mv / 100);
  // a grounded pin reads 0 V, otherwise pull-up lifts a latched-open pin
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      pin_mv[i] = gnd_short[i] ? 0 : pull_req[i] ? 5000 : led_mv[i];
      ch_short[i] = pin_mv[i] > short_mv;
      ch_open[i] = pin_mv[i] <= 200;
    end
  end
endmodule : analog_side
`default_nettype wire

// File: tb.sv
/*
  Self-checking bench: start-up, converter gating, system and channel timers,
  dimming holds and shutdown. Assumes analog_side stands at the far side.
*/
`timescale 1ns/10ps
`default_nettype none
module tb;
  import prot_pkg::*;
  localparam int OC = 4;
  localparam int SC = 6;
  localparam int LC = 8;
  logic clk, rst, tick, stb, lk_hi, lk_lo, su_hi, su_lo, output_short_protect, ocl, rt_low, current_set_pin_low, ss_done, sd_done;
  logic f_o, f_oe, conv, fbov, irst, act, sup, arm, lat, ov_lo, ov_hi;
  logic [5:0] dim, ch_short, ch_open, ch_out, pull, gnd, fb, fbh;
  logic [4:0] ov_code, ovh;
  int vout, led_short_threshold_set, led [6];
  typedef struct {int sel; logic [7:0] exp;} note_s;
  note_s notes [$];
  note_s nt;
  int num_errors = 0;
  int checks = 0;
  int c, n, v, f;
  logic [31:0] seed = 32'h0000_0047;
  logic [2:0] hys [4] = '{3'h1, 3'h2, 3'h0, 3'h5};
  logic [7:0] obs [13];
  string nm [13] = '{"flag_oe", "conv_en", "ch_out", "pullup", "ov_hold", "fb_hold", "fb_from_ov", "int_reset",
    "active", "stepup", "armed", "sys_latch", "flag_o"};

  analog_side side (.pull_req(pull), .vout_mv(vout), .lsp_mv(led_short_threshold_set), .led_mv(led), .gnd_short(gnd), .ovp_lo(ov_lo),
    .ovp_hi(ov_hi), .ovp_code(ov_code), .ch_short(ch_short), .ch_open(ch_open));
  led_fault_protection_sequencer #(.OVP_COUNT(OC), .SCP_COUNT(SC), .LED_COUNT(LC)) dut (.CLK(clk), .RST(rst),
    .TICK(tick), .STANDBY_ENABLE(stb), .LOCKOUT_ABOVE_HI(lk_hi), .LOCKOUT_BELOW_LO(lk_lo), .STEPUP_ABOVE_HI(su_hi),
    .STEPUP_BELOW_LO(su_lo), .OVERVOLTAGE_ABOVE_LO(ov_lo), .OVERVOLTAGE_ABOVE_HI(ov_hi), .OUTPUT_SHORT_PROTECT(output_short_protect),
    .INDUCTOR_CURRENT_LIMIT(ocl), .FREQUENCY_SET_LOW(rt_low), .CURRENT_SET_LOW(current_set_pin_low), .SOFTSTART_DONE(ss_done),
    .SHUTDOWN_DONE(sd_done), .DIMMING(dim), .CHANNEL_SHORT(ch_short), .CHANNEL_OPEN_FLAG(ch_open),
    .OVERVOLTAGE_LEVEL(ov_code), .FEEDBACK_LEVEL(fb), .FAULT_FLAG_O(f_o), .FAULT_FLAG_OE(f_oe),
    .CONVERTER_ENABLE(conv), .CHANNEL_OUTPUTS(ch_out), .CHANNEL_PULLUP(pull), .OVERVOLTAGE_HOLD(ovh),
    .FEEDBACK_HOLD(fbh), .FEEDBACK_FROM_OVERVOLTAGE(fbov), .INTERNAL_RESET(irst), .DEVICE_ACTIVE(act),
    .STEPUP_ENABLE(sup), .LED_PROTECT_ARMED(arm), .SYSTEM_LATCHED(lat));

  // observed outputs, indexed like nm
  assign obs = '{8'(f_oe), 8'(conv), 8'(ch_out), 8'(pull), 8'(ovh), 8'(fbh), 8'(fbov), 8'(irst), 8'(act), 8'(sup),
    8'(arm), 8'(lat), 8'(f_o)};

  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic wrap_up();
    if (num_errors == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : wrap_up

  task automatic cmp(input int s, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm[s], e, g);
    end
  endtask : cmp

  // each settled sample answers all pending notes, oldest first
  always @(negedge clk) begin
    while (notes.size() > 0) begin
      nt = notes.pop_front();
      cmp(nt.sel, nt.exp, obs[nt.sel]);
    end
  end

  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : step

  task automatic want(input int s, input logic [7:0] e);
    notes.push_back('{s, e});
  endtask : want

  task automatic ticks(input int k);
    repeat (k) begin
      tick = 1'b1;
      step(1);
    end
    tick = 1'b0;
  endtask : ticks

  task automatic wait_for(input int s, input logic [7:0] e, input int bound);
    n = 0;
    while (obs[s] !== e && n < bound) begin
      step(1);
      n++;
    end
    cmp(s, e, obs[s]);
    if (obs[s] !== e) wrap_up();
  endtask : wait_for

  // reset, quiet analog side, then dimming with enable
  task automatic power_up();
    rst = 1'b1;
    {stb, lk_lo, su_lo, output_short_protect, ocl, rt_low, current_set_pin_low, ss_done, sd_done} = '0;
    gnd = '0;
    vout = 2500;
    led = '{6{1000}};
    step(2);
    rst = 1'b0;
    dim = 6'h3F;
    {stb, lk_hi, su_hi} = 3'h7;
    wait_for(8, 8'h01, 10);
    step(3);
    want(0, 8'h01);
    want(9, 8'h01);
    want(1, 8'h01);
    want(2, 8'h3F);
    want(12, 8'h00);
  endtask : power_up

  initial begin
    {tick, lk_hi, su_hi} = '0;
    {dim, fb} = '0;
    led_short_threshold_set = 0;
    power_up();
    // step-up hysteresis
    for (int k = 0; k < 4; k++) begin
      {su_hi, su_lo} = hys[k][2:1];
      step(3);
      want(9, 8'(hys[k][0]));
    end
    // converter stops for current limit, low frequency-set pin and upper overvoltage trip, and comes back by itself
    for (int k = 0; k < 3; k++) begin
      ocl = (k == 0);
      rt_low = (k == 1);
      vout = (k == 2) ? 3100 : 2500;
      step(3);
      want(1, 8'h00);
      {ocl, rt_low} = 2'b00;
      vout = 2500;
      step(3);
      want(1, 8'h01);
    end
    // low current setting drops channels and opens the flag
    current_set_pin_low = 1'b1;
    step(3);
    want(2, 8'h00);
    want(0, 8'h00);
    current_set_pin_low = 1'b0;
    step(3);
    want(2, 8'h3F);
    want(0, 8'h01);
    // overvoltage timer restarts after a drop, then latches
    vout = 2950;
    ticks(OC - 1);
    vout = 2500;
    step(2);
    vout = 2950;
    ticks(OC - 1);
    step(2);
    want(11, 8'h00);
    want(1, 8'h01);
    tick = 1'b1;
    wait_for(11, 8'h01, 1);
    tick = 1'b0;
    step(3);
    want(0, 8'h00);
    want(1, 8'h00);
    // shutdown with the timer still running, the latch it sets is cleared by the reset strobe, then shutdown completes, then restart
    power_up();
    vout = 2950;
    ticks(OC - 1);
    stb = 1'b0;
    step(3);
    want(7, 8'h01);
    want(8, 8'h00);
    want(1, 8'h00);
    want(2, 8'h3F);
    tick = 1'b1;
    wait_for(11, 8'h01, 1);
    tick = 1'b0;
    vout = 2500;
    wait_for(7, 8'h00, 210);
    sd_done = 1'b1;
    step(3);
    want(11, 8'h00);
    sd_done = 1'b0;
    stb = 1'b1;
    step(3);
    want(8, 8'h01);
    want(0, 8'h01);
    // output short: converter off at once, latch after full count
    power_up();
    output_short_protect = 1'b1;
    ticks(SC - 2);
    step(2);
    want(1, 8'h00);
    want(11, 8'h00);
    tick = 1'b1;
    wait_for(11, 8'h01, 2);
    tick = 1'b0;
    step(3);
    want(2, 8'h00);
    // channel short ignored before soft start ends, then latches alone
    power_up();
    c = rnd() % 6;
    led[c] = 9500;
    ticks(LC + 6);
    step(2);
    want(2, 8'h3F);
    ss_done = 1'b1;
    ticks(LC - 2);
    step(2);
    want(10, 8'h01);
    want(2, 8'h3F);
    tick = 1'b1;
    wait_for(2, 8'(6'h3F ^ (6'h01 << c)), 4);
    tick = 1'b0;
    step(2);
    want(0, 8'h00);
    // open pin with short dimming pulses stays masked, then latches
    power_up();
    ss_done = 1'b1;
    c = (c + 2) % 6;
    led[c] = 100;
    tick = 1'b1;
    repeat (LC + 4) begin
      dim[c] = 1'b0;
      step(1);
      dim[c] = 1'b1;
      step(3);
    end
    tick = 1'b0;
    step(2);
    want(2, 8'h3F);
    tick = 1'b1;
    wait_for(2, 8'(6'h3F ^ (6'h01 << c)), LC + 2);
    tick = 1'b0;
    // grounded pin stays low after pull-up, system latches after 128
    power_up();
    ss_done = 1'b1;
    gnd[c] = 1'b1;
    tick = 1'b1;
    wait_for(3, 8'(6'h01 << c), LC + 4);
    step(120);
    tick = 1'b0;
    step(2);
    want(11, 8'h00);
    tick = 1'b1;
    wait_for(11, 8'h01, 9);
    tick = 1'b0;
    // dimming falling edge holds sense and feedback codes
    power_up();
    repeat (3) begin
      v = rnd() % 3600;
      f = rnd() % 64;
      vout = v;
      fb = 6'(f);
      step(3);
      dim = 6'h00;
      step(4);
      want(4, 8'((v >= 3000) ? 30 : v / 100));
      want(5, 8'((f > 40) ? 40 : f));
      want(6, 8'h01);
      vout = rnd() % 2900;
      fb = 6'(rnd() % 64);
      step(3);
      want(4, 8'((v >= 3000) ? 30 : v / 100));
      want(5, 8'((f > 40) ? 40 : f));
      dim = 6'h3F;
      step(3);
      want(6, 8'h00);
    end
    // supply lockout shuts the device down
    {lk_hi, lk_lo} = 2'b01;
    step(3);
    want(8, 8'h00);
    step(2);
    wrap_up();
  end
endmodule : tb
`default_nettype wire
